// ---- erc_pkg.sv ----
// ==========================================================
// shared constants of the 8-bit core
package erc_pkg;

  // widths
  localparam int INSN_W = 12;  // one instruction per program word
  localparam int DATA_W = 8;  // alu and register width
  localparam int PC_W = 11;  // reaches the larger program store
  localparam int RF_AW = 5;  // register file address width
  localparam int RF_DEPTH = 32;
  localparam int NIB_W = 4;  // low nibble for the nibble carry

  // program store sizes, in 12-bit words
  localparam int PM_SMALL_WORDS = 512;
  localparam int PM_LARGE_WORDS = 2048;
  localparam logic [PC_W-1:0] PC_SMALL_MASK = PC_W'(PM_SMALL_WORDS - 1);
  localparam logic [PC_W-1:0] PC_LARGE_MASK = PC_W'(PM_LARGE_WORDS - 1);
  localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;

  // register file map
  localparam logic [RF_AW-1:0] ADDR_INDIRECT = 5'h00;
  localparam logic [RF_AW-1:0] ADDR_PCL = 5'h02;
  localparam logic [RF_AW-1:0] ADDR_STATUS = 5'h03;
  localparam logic [RF_AW-1:0] ADDR_FSR = 5'h04;
  localparam logic [RF_AW-1:0] ADDR_GPR_FIRST = 5'h05;

  // status bit positions and reset values
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PAGE = 5;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FSR_RESET = 8'h00;

  // instruction classes, top two bits
  localparam logic [1:0] CLS_FILE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_LIT = 2'h2;
  localparam logic [1:0] CLS_GOTO = 2'h3;

  // file operations, bits 9:6
  localparam logic [3:0] OP_MOVWF = 4'h0;  // destination clear: no operation
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;  // subtract_acc_from_file
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;  // add_acc_to_file
  localparam logic [3:0] OP_MOVF = 4'h8;
  localparam logic [3:0] OP_COMF = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRF = 4'hC;
  localparam logic [3:0] OP_RLF = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;

  // literal operations, bits 9:8
  localparam logic [1:0] LOP_MOV = 2'h0;
  localparam logic [1:0] LOP_AND = 2'h1;
  localparam logic [1:0] LOP_IOR = 2'h2;
  localparam logic [1:0] LOP_XOR = 2'h3;

  // bit operations, bits 9:8
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKC = 2'h2;
  localparam logic [1:0] BOP_SKS = 2'h3;

  // quarter clock divider
  localparam int QDIV_W = 2;  // four input cycles per output cycle

  // pipeline state
  typedef enum logic [1:0] {
    PIPE_FLUSH = 2'b01,  // fetched word is discarded
    PIPE_EXEC = 2'b10  // fetched word executes
  } erc_pipe_e;

endpackage

// ---- erc_core.sv ----
`timescale 1ns/1ps
// Functional notes
// - instruction word is twelve bits wide
// - one instruction fetched per cycle
// - fetch overlaps execution in two stages
// - non-branch instructions take one cycle
// - branches take two cycles, discarding prefetch
// - program store 512 or 2048 words
// - separate program and data buses
// - special registers and pc in data map
// - direct and indirect register addressing
// - eight-bit alu: add, sub, shift, logic
// - arithmetic is two's complement
// - two operands: accumulator plus file/literal
// - one operand: accumulator or file
// - accumulator eight bits, no address
// - alu updates carry, nibble carry, zero
// - subtraction carries act as inverted borrows
// - rc mode drives quarter-rate clock out
module erc_core
  import erc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // device pins
  input wire logic external_reset_n,
  input wire logic rc_mode,
  input wire logic small_variant,
  output logic quarter_clock_output,
  // program memory bus
  output logic [PC_W-1:0] prog_addr,
  input wire logic [INSN_W-1:0] prog_data,
  // visible core state
  output logic [DATA_W-1:0] acc_out,
  output logic [DATA_W-1:0] status_out
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] rst_pin_sync_reg;  // external_reset_n, two flops
  logic [1:0] rc_sync_reg;  // rc_mode, two flops
  logic [1:0] small_sync_reg;  // small_variant, two flops
  logic core_rst;  // any reset source

  // pins come from outside the clock domain
  always_ff @(posedge clock)
  begin
    rst_pin_sync_reg <= {rst_pin_sync_reg[0], external_reset_n};
    rc_sync_reg <= {rc_sync_reg[0], rc_mode};
    small_sync_reg <= {small_sync_reg[0], small_variant};
  end

  // a low pin level is a reset request, not an edge
  assign core_rst = !rstn || !rst_pin_sync_reg[1];

  // ==========================================================
  // core state
  logic [PC_W-1:0] pc_reg, pc_next;  // fetch address
  logic [INSN_W-1:0] ir_reg;  // instruction being executed
  erc_pipe_e pipe_reg, pipe_next;
  logic [DATA_W-1:0] acc_reg, acc_next;  // not in the file map
  logic [DATA_W-1:0] status_reg, status_next;
  logic [DATA_W-1:0] fsr_reg, fsr_next;  // indirect pointer
  logic [DATA_W-1:0] ram [RF_DEPTH];  // general registers
  logic [QDIV_W-1:0] qdiv_reg;  // quarter clock phase
  logic qclk_reg;

  // ==========================================================
  // decode
  logic cls_file, cls_bit, cls_lit, cls_goto;
  logic [3:0] fop;
  logic [1:0] sop;
  logic dest_file;
  logic [RF_AW-1:0] fdirect, faddr;
  logic [2:0] bit_sel;
  logic [DATA_W-1:0] lit;
  logic executing;

  assign executing = pipe_reg == PIPE_EXEC;
  assign cls_file = ir_reg[11:10] == CLS_FILE;
  assign cls_bit = ir_reg[11:10] == CLS_BIT;
  assign cls_lit = ir_reg[11:10] == CLS_LIT;
  assign cls_goto = ir_reg[11:10] == CLS_GOTO;
  assign fop = ir_reg[9:6];
  assign sop = ir_reg[9:8];
  assign dest_file = ir_reg[5];
  assign bit_sel = ir_reg[7:5];
  assign lit = ir_reg[7:0];
  assign fdirect = ir_reg[4:0];
  // address zero reaches the register that the pointer names
  assign faddr = (fdirect == ADDR_INDIRECT) ? fsr_reg[RF_AW-1:0] : fdirect;

  // ==========================================================
  // data bus read, separate from the program bus
  logic [DATA_W-1:0] fval;
  // special registers read like any file, pc low byte included
  assign fval = (faddr == ADDR_INDIRECT) ? '0 :
                (faddr == ADDR_PCL) ? pc_reg[DATA_W-1:0] :
                (faddr == ADDR_STATUS) ? status_reg :
                (faddr == ADDR_FSR) ? fsr_reg : ram[faddr];

  // ==========================================================
  // alu
  logic [DATA_W:0] add_sum, sub_sum;
  logic [NIB_W:0] add_nib, sub_nib;
  logic [DATA_W-1:0] inc_v, dec_v, bit_mask;
  logic cin;

  assign cin = status_reg[ST_C];
  // file plus accumulator, two's complement wraps
  assign add_sum = {1'b0, fval} + {1'b0, acc_reg};
  assign add_nib = {1'b0, fval[NIB_W-1:0]} + {1'b0, acc_reg[NIB_W-1:0]};
  // file minus accumulator as file plus inverted accumulator plus one;
  // the carry out is then high exactly when no borrow happened
  assign sub_sum = {1'b0, fval} + {1'b0, ~acc_reg} + 9'h001;
  assign sub_nib = {1'b0, fval[NIB_W-1:0]} + {1'b0, ~acc_reg[NIB_W-1:0]} + 5'h01;
  assign inc_v = fval + 8'h01;
  assign dec_v = fval - 8'h01;
  assign bit_mask = 8'h01 << bit_sel;

  logic [DATA_W-1:0] res;
  logic res_valid, upd_z, upd_c, upd_dc, new_c, new_dc;
  logic wr_file, wr_acc, skip;

  // result and flag selection for the instruction in execute
  always_comb
  begin
    res = fval;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    new_c = cin;
    new_dc = status_reg[ST_DC];
    skip = 1'b0;
    res_valid = 1'b1;
    if (cls_file)
    begin
      // single operand forms act on file or accumulator
      unique case (fop)
        OP_MOVWF: begin res = acc_reg; res_valid = dest_file; end
        OP_CLR: begin res = '0; upd_z = 1'b1; end
        OP_SUB:
        begin
          res = sub_sum[DATA_W-1:0];
          {upd_z, upd_c, upd_dc} = 3'h7;
          new_c = sub_sum[DATA_W];
          new_dc = sub_nib[NIB_W];
        end
        OP_DEC: begin res = dec_v; upd_z = 1'b1; end
        OP_IOR: begin res = fval | acc_reg; upd_z = 1'b1; end
        OP_AND: begin res = fval & acc_reg; upd_z = 1'b1; end
        OP_XOR: begin res = fval ^ acc_reg; upd_z = 1'b1; end
        OP_ADD:
        begin
          res = add_sum[DATA_W-1:0];
          {upd_z, upd_c, upd_dc} = 3'h7;
          new_c = add_sum[DATA_W];
          new_dc = add_nib[NIB_W];
        end
        OP_MOVF: begin res = fval; upd_z = 1'b1; end
        OP_COMF: begin res = ~fval; upd_z = 1'b1; end
        OP_INC: begin res = inc_v; upd_z = 1'b1; end
        OP_DECSZ: begin res = dec_v; skip = dec_v == '0; end
        // rotates run through the carry
        OP_RRF: begin res = {cin, fval[DATA_W-1:1]}; upd_c = 1'b1; new_c = fval[0]; end
        OP_RLF: begin res = {fval[DATA_W-2:0], cin}; upd_c = 1'b1; new_c = fval[DATA_W-1]; end
        OP_SWAP: res = {fval[NIB_W-1:0], fval[DATA_W-1:NIB_W]};
        OP_INCSZ: begin res = inc_v; skip = inc_v == '0; end
      endcase
    end
    else if (cls_bit)
    begin
      unique case (sop)
        BOP_CLR: res = fval & ~bit_mask;
        BOP_SET: res = fval | bit_mask;
        BOP_SKC: begin res_valid = 1'b0; skip = (fval & bit_mask) == '0; end
        BOP_SKS: begin res_valid = 1'b0; skip = (fval & bit_mask) != '0; end
      endcase
    end
    else if (cls_lit)
    begin
      // literal is the second operand
      upd_z = sop != LOP_MOV;
      unique case (sop)
        LOP_MOV: res = lit;
        LOP_AND: res = lit & acc_reg;
        LOP_IOR: res = lit | acc_reg;
        LOP_XOR: res = lit ^ acc_reg;
      endcase
    end
    else
    begin
      res_valid = 1'b0;
    end
  end

  // destination: bit clear/set and d=1 write the file, literals the accumulator
  assign wr_file = executing && res_valid && (cls_bit || (cls_file && dest_file));
  assign wr_acc = executing && res_valid && (cls_lit || (cls_file && !dest_file));

  // ==========================================================
  // next state and program flow
  logic pcl_write, take_branch;
  logic [PC_W-1:0] pc_mask, pc_inc, goto_target, pcl_target;

  // the small variant wraps inside its smaller store
  assign pc_mask = small_sync_reg[1] ? PC_SMALL_MASK : PC_LARGE_MASK;
  assign pc_inc = (pc_reg + 11'h001) & pc_mask;
  assign goto_target = {status_reg[ST_PAGE], ir_reg[9:0]} & pc_mask;
  assign pcl_target = {status_reg[ST_PAGE], 2'h0, res} & pc_mask;
  assign pcl_write = wr_file && faddr == ADDR_PCL;
  // a taken branch or skip spoils the prefetched word
  assign take_branch = executing && (cls_goto || skip || pcl_write);

  // one word fetched each cycle while the previous one executes
  always_comb
  begin
    pc_next = pc_inc;
    if (executing && cls_goto)
      pc_next = goto_target;
    else if (pcl_write)
      pc_next = pcl_target;
    // non-branch instructions retire every cycle
    pipe_next = take_branch ? PIPE_FLUSH : PIPE_EXEC;
  end

  // register file side effects
  always_comb
  begin
    acc_next = wr_acc ? res : acc_reg;
    fsr_next = (wr_file && faddr == ADDR_FSR) ? res : fsr_reg;
    status_next = status_reg;
    if (executing)
    begin
      if (upd_z)
        status_next[ST_Z] = res == '0;
      if (upd_c)
        status_next[ST_C] = new_c;
      if (upd_dc)
        status_next[ST_DC] = new_dc;
    end
    // an explicit write to status overrides the flag update
    if (wr_file && faddr == ADDR_STATUS)
      status_next = res;
  end

  // ==========================================================
  // pipeline and program counter
  always_ff @(posedge clock)
  begin
    if (core_rst)
    begin
      pc_reg <= RESET_VECTOR;
      ir_reg <= '0;
      pipe_reg <= PIPE_FLUSH;  // nothing fetched yet
    end
    else
    begin
      pc_reg <= pc_next;
      ir_reg <= prog_data;
      pipe_reg <= pipe_next;
    end
  end

  // working registers
  always_ff @(posedge clock)
  begin
    if (core_rst)
    begin
      acc_reg <= ACC_RESET;
      status_reg <= STATUS_RESET;
      fsr_reg <= FSR_RESET;
    end
    else
    begin
      acc_reg <= acc_next;
      status_reg <= status_next;
      fsr_reg <= fsr_next;
    end
  end

  // general registers keep their contents through reset
  always_ff @(posedge clock)
  begin
    if (!core_rst && wr_file && faddr >= ADDR_GPR_FIRST)
      ram[faddr] <= res;
  end

  // ==========================================================
  // quarter rate clock output, rc mode only
  always_ff @(posedge clock)
  begin
    if (core_rst)
    begin
      qdiv_reg <= '0;
      qclk_reg <= 1'b0;
    end
    else
    begin
      qdiv_reg <= qdiv_reg + QDIV_W'(1);
      // high for two of four input cycles; held low outside rc mode
      qclk_reg <= rc_sync_reg[1] && qdiv_reg[QDIV_W-1];
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign prog_addr = pc_reg;
  assign acc_out = acc_reg;
  assign status_out = status_reg;
  assign quarter_clock_output = qclk_reg;

endmodule

// ---- erc_prog_mem.sv ----
`timescale 1ns/1ps
// ==========================================================
// program store model facing the core fetch bus
module erc_prog_mem
  import erc_pkg::*;
(
  // fetch bus
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic small_variant,
  output logic [INSN_W-1:0] prog_data
);
  // one 12-bit word per location, loaded by the bench
  logic [INSN_W-1:0] mem [PM_LARGE_WORDS];
  // small store folds the address, so words above 511 alias low ones
  wire [PC_W-1:0] eff_addr = small_variant ? (prog_addr & PC_SMALL_MASK) : prog_addr;
  // combinational read: a whole word every cycle
  assign prog_data = mem[eff_addr];
  // blank store reads as no-operation words
  initial
  begin
    for (int i = 0; i < PM_LARGE_WORDS; i++)
      mem[i] = 12'h000;
  end
endmodule

// ---- erc_assertions.sv ----
`timescale 1ns/1ps
// ==========================================================
// port-level checks of the core
module erc_assertions
  import erc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // pins
  input wire logic external_reset_n,
  input wire logic rc_mode,
  input wire logic small_variant,
  input wire logic quarter_clock_output,
  // fetch bus and state
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [INSN_W-1:0] prog_data,
  input wire logic [DATA_W-1:0] acc_out,
  input wire logic [DATA_W-1:0] status_out
);
  // cycles since the pin reset went high; covers the synchroniser delay
  logic [2:0] ext_hi_reg;
  wire settled = rstn && (ext_hi_reg == 3'h7);
  // saturating count, cleared by the pin; a plain rstn reset leaves only one
  // cycle of fetch history to gather, so checks start at the second edge after it
  // limitation: assumes the pin stood high for a few edges before rstn rose
  always_ff @(posedge clock)
  begin
    if (!external_reset_n)
      ext_hi_reg <= 3'h0;
    else if (!rstn)
      ext_hi_reg <= 3'h6;
    else if (ext_hi_reg != 3'h7)
      ext_hi_reg <= ext_hi_reg + 3'h1;
  end
  // ==========================================================
  // assertions
  rst_clears_a: assert property (@(posedge clock) !rstn |=> acc_out == ACC_RESET &&
    prog_addr == RESET_VECTOR && status_out == STATUS_RESET && !quarter_clock_output)
    else $error("core state not cleared by reset");
  pin_reset_a: assert property (@(posedge clock) (!external_reset_n)[*5] |->
    acc_out == ACC_RESET && prog_addr == RESET_VECTOR && status_out == STATUS_RESET)
    else $error("pin reset did not clear core state");
  small_store_a: assert property (@(posedge clock) disable iff (!rstn)
    small_variant[*4] |-> prog_addr <= PC_SMALL_MASK) else $error("pc beyond small store");
  seq_fetch_a: assert property (@(posedge clock) disable iff (!rstn || !external_reset_n)
    settled && $past(prog_data[11:10]) == CLS_LIT && prog_addr != PC_LARGE_MASK
    |=> prog_addr == $past(prog_addr) + 11'h001) else $error("fetch did not advance by one");
  lit_load_a: assert property (@(posedge clock) disable iff (!rstn || !external_reset_n)
    settled && $past(prog_data[11:10]) == CLS_LIT && prog_data[11:8] == {CLS_LIT, LOP_MOV}
    |-> ##2 acc_out == $past(prog_data[7:0], 2)) else $error("literal not in accumulator");
  goto_jump_a: assert property (@(posedge clock) disable iff (!rstn || !external_reset_n)
    settled && $past(prog_data[11:10]) == CLS_LIT && prog_data[11:10] == CLS_GOTO &&
    !status_out[ST_PAGE] |=> prog_addr == $past(prog_addr) + 11'h001
    ##1 prog_addr == {1'b0, $past(prog_data[9:0], 2)}) else $error("branch timing wrong");
  quarter_wave_a: assert property (@(posedge clock) disable iff (!rstn || !rc_mode)
    $rose(quarter_clock_output) |=> quarter_clock_output ##1 !quarter_clock_output
    ##1 !quarter_clock_output ##1 quarter_clock_output) else $error("quarter clock shape wrong");
  quarter_off_a: assert property (@(posedge clock) disable iff (!rstn)
    (!rc_mode)[*4] |-> !quarter_clock_output) else $error("quarter clock outside rc mode");
  // ==========================================================
  // covers
  cover property (@(posedge clock) $rose(quarter_clock_output));
  cover property (@(posedge clock) settled && prog_data[11:10] == CLS_GOTO);
  cover property (@(posedge clock) (!external_reset_n)[*5]);
endmodule

bind erc_core erc_assertions i_erc_assertions (.clock(clock), .rstn(rstn),
  .external_reset_n(external_reset_n), .rc_mode(rc_mode), .small_variant(small_variant),
  .quarter_clock_output(quarter_clock_output), .prog_addr(prog_addr), .prog_data(prog_data),
  .acc_out(acc_out), .status_out(status_out));

// ---- tb_top.sv ----
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the core
module tb_top;
  import erc_pkg::*;
  logic clock, rstn, external_reset_n, rc_mode, small_variant;
  logic quarter_clock_output;
  logic [PC_W-1:0] prog_addr;
  logic [INSN_W-1:0] prog_data;
  logic [DATA_W-1:0] acc_out, status_out;
  int errors, check_count;
  erc_core i_erc_core (.clock(clock), .rstn(rstn), .external_reset_n(external_reset_n),
    .rc_mode(rc_mode), .small_variant(small_variant),
    .quarter_clock_output(quarter_clock_output), .prog_addr(prog_addr),
    .prog_data(prog_data), .acc_out(acc_out), .status_out(status_out));
  erc_prog_mem i_erc_prog_mem (.prog_addr(prog_addr), .small_variant(small_variant),
    .prog_data(prog_data));
  // 25 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // load five words under reset, run until the halt loop at word 4
  task automatic run_prog(input logic [11:0] p [5]);
    int n;
    rstn = 1'b0;
    for (int i = 0; i < 5; i++)
      i_erc_prog_mem.mem[i] = p[i];
    tick(10);
    rstn = 1'b1;
    n = 0;
    while (prog_addr !== 11'h004 && n < 50)
    begin
      tick(1);
      n++;
    end
    if (n == 50)
    begin
      errors++;
      conclude();
    end
    tick(4);
  endtask
  // ==========================================================
  // scenarios
  // 5 - 7 borrows from both nibble and byte: flags read clear
  task automatic s_sub_borrow;
    run_prog('{12'h805, 12'h025, 12'h807, 12'h085, 12'hC04});
    check("acc", 12'(acc_out), 12'h0FE);
    check("flags", 12'(status_out[2:0]), 12'h000);
  endtask
  // back-to-back literal moves: the second lands one cycle after the first
  task automatic s_lit_chain;
    run_prog('{12'h8A5, 12'h83C, 12'h000, 12'h000, 12'hC04});
    check("acc", 12'(acc_out), 12'h03C);
  endtask
  // 0x0F + 0x01 carries out of the low nibble only
  task automatic s_add_nibble;
    run_prog('{12'h80F, 12'h026, 12'h801, 12'h1C6, 12'hC04});
    check("acc", 12'(acc_out), 12'h010);
    check("flags", 12'(status_out[2:0]), 12'h002);
  endtask
  // equal operands in the small store: no borrow, zero result;
  // then a jump to the top of the small store wraps the pc back to zero
  task automatic s_sub_zero;
    small_variant = 1'b1;
    i_erc_prog_mem.mem[PM_SMALL_WORDS-1] = 12'hC04;
    run_prog('{12'h833, 12'h027, 12'h087, 12'hFFF, 12'hC04});
    check("acc", 12'(acc_out), 12'h000);
    check("flags", 12'(status_out[2:0]), 12'h007);
    small_variant = 1'b0;
  endtask
  // the word after a taken branch must never execute
  task automatic s_branch;
    run_prog('{12'h801, 12'hC03, 12'h8AA, 12'h000, 12'hC04});
    check("acc", 12'(acc_out), 12'h001);
  endtask
  // two high and two low cycles, silent once rc mode ends
  task automatic s_quarter;
    int ones;
    rc_mode = 1'b1;
    tick(6);
    ones = 0;
    repeat (8)
    begin
      if (quarter_clock_output === 1'b1)
        ones++;
      tick(1);
    end
    check("quarter duty", 12'(ones), 12'h004);
    rc_mode = 1'b0;
    tick(5);
    check("quarter idle", 12'(quarter_clock_output), 12'h000);
  endtask
  // pin reset clears the accumulator left by the branch test
  task automatic s_pin_reset;
    i_erc_prog_mem.mem[0] = 12'hC00;
    external_reset_n = 1'b0;
    tick(6);
    check("acc in reset", 12'(acc_out), 12'h000);
    check("pc in reset", 12'(prog_addr), 12'h000);
    external_reset_n = 1'b1;
    tick(6);
    check("status after", 12'(status_out), 12'h000);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    errors = 0;
    check_count = 0;
    rstn = 1'b0;
    external_reset_n = 1'b1;
    rc_mode = 1'b0;
    small_variant = 1'b0;
    tick(10);
    s_sub_borrow();
    s_lit_chain();
    s_add_nibble();
    s_sub_zero();
    s_branch();
    s_quarter();
    s_pin_reset();
    conclude();
  end
endmodule
